// [rtl/mft_cfg.svh]
// Register map, field positions, reset values and codes of the timer block.
// Assumes byte addresses on a 32-bit Avalon-MM bus, one register per word.
`ifndef MFT_CFG_SVH
`define MFT_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MFT_OFF_RUN      9'h000
`define MFT_OFF_RUN5     9'h004
`define MFT_OFF_SYNC     9'h008
`define MFT_OFF_ADCR     9'h00C
`define MFT_OFF_CYC_A    9'h010
`define MFT_OFF_CYC_B    9'h014
`define MFT_OFF_BUF_A    9'h018
`define MFT_OFF_BUF_B    9'h01C
`define MFT_OFF_UPDN     9'h020
`define MFT_OFF_CNT      9'h040
`define MFT_SPAN_CNT     9'h020
`define MFT_OFF_GEN      9'h080
`define MFT_SPAN_GEN     9'h054
`define MFT_OFF_CTL      9'h100
`define MFT_SPAN_CTL     9'h018

// ----------------------------------------------------------------------
// Writable bit masks, reserved bits read zero
// ----------------------------------------------------------------------
`define MFT_RUN_MASK     8'hC7
`define MFT_RUN5_MASK    8'h07
`define MFT_SYNC_MASK    8'hC7
`define MFT_ADCR_MASK    16'hC0F0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MFT_BF_POS       14
`define MFT_UT_A_POS     7
`define MFT_DT_A_POS     6
`define MFT_UT_B_POS     5
`define MFT_DT_B_POS     4
`define MFT_CTL_BUF_POS  3
`define MFT_CTL_MODE_POS 4
`define MFT_CTL_INIT_POS 16
`define MFT_CTL_EREQ_POS 22

// ----------------------------------------------------------------------
// Reset values and clear source codes
// ----------------------------------------------------------------------
`define MFT_CNT_RST      16'h0000
`define MFT_GEN_RST      16'hFFFF
`define MFT_CYC_RST      16'hFFFF
`define MFT_CLR_A        3'h1
`define MFT_CLR_B        3'h2
`define MFT_CLR_SYNC     3'h3
`define MFT_CLR_C        3'h5
`define MFT_CLR_D        3'h6

`endif

// [rtl/mft_pkg.sv]
// Types shared by the timer block.
// Assumes mft_cfg.svh supplies the numeric constants.
package mft_pkg;

  // Per general register operating mode
  typedef enum logic [1:0] {
    MFT_COMPARE = 2'h0,
    MFT_CAPTURE = 2'h1,
    MFT_WIDTH   = 2'h2
  } mft_mode_type;

  // Whole state of the block
  typedef struct packed {
    logic [7:0][15:0]  cnt;
    logic [20:0][15:0] gen;
    logic [3:0][15:0]  cyc;
    logic [7:0]        run_ctl;
    logic [7:0]        run5;
    logic [7:0]        sync;
    logic [15:0]       adcr;
    logic              updown;
    logic              dir_down;
    logic [5:0][22:0]  chctl;
    logic [20:0]       pin;
    logic [20:0]       pin_oe_n;
    logic [20:0]       cap_prev;
    logic              trg_a;
    logic              trg_b;
    logic              trg_e;
    logic              waitrequest;
    logic [31:0]       rdata;
  } mft_state_type;

endpackage

// [rtl/mft_timer.sv]
// Multi-channel 16-bit timer: counters, general registers, start and sync.
// Assumes a 32-bit Avalon-MM master with byte addresses, and capture
// inputs synchronous to clock.
//
// Overview of operation
// - Cycle registers match counter 4, request conversion
// - Cycle buffers copy at crest or trough
// - Eight counters, reset to zero
// - Twenty-one general registers, reset to ones
// - Registers A-D compare or capture
// - C buffers A, D buffers B
// - Register E match requests conversion, F buffers
// - Channel 5 compare, capture, width measure
// - Start register runs counters zero to four
// - Stopping holds pin output level
// - Control write while stopped loads pin level
// - Channel 5 start bits run U,V,W
// - Sync bits select synchronous channels
// - Sync preset and sync clear together
// - Reserved bits read zero, written zero
// - Transfer timing: none, crest, trough, both
// - Cycle register conversion requests gated by direction enables
`timescale 1ns/100ps
`include "mft_cfg.svh"

module mft_timer
  import mft_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [8:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [20:0] capture_in,
  output logic [20:0]      timer_io_pin_out,
  output logic [20:0]      timer_io_pin_oe_n,
  output logic             adc_start_request_a,
  output logic             adc_start_request_b,
  output logic             ch0_adc_request
);

  // ----------------------------------------------------------------------
  // Register layout helpers
  // ----------------------------------------------------------------------

  // Channel owning general register j
  function automatic int reg_chan(input int j);
    if (j < 6) begin
      return 0;
    end else if (j < 8) begin
      return 1;
    end else if (j < 10) begin
      return 2;
    end else if (j < 14) begin
      return 3;
    end else if (j < 18) begin
      return 4;
    end
    return 5;
  endfunction

  // First general register of channel c
  function automatic int reg_base(input int c);
    case (c)
      0: return 0;
      1: return 6;
      2: return 8;
      3: return 10;
      4: return 14;
      default: return 18;
    endcase
  endfunction

  // Reset image of the whole state
  localparam mft_state_type ST_RST = '{
    gen:         {21{`MFT_GEN_RST}},
    cyc:         {4{`MFT_CYC_RST}},
    pin_oe_n:    '1,
    waitrequest: 1'b1,
    default:     '0
  };

  mft_state_type st_reg;
  mft_state_type st_next;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0]  run;
    logic [20:0] cmp;
    logic [20:0] ev;
    logic [2:0]  wmode;
    logic [4:0]  own_clr;
    logic [4:0]  clr;
    logic [4:0]  syncv;
    logic [2:0]  src;
    logic [1:0]  md;
    logic [1:0]  bf;
    logic        crest;
    logic        trough;
    logic        wr;
    logic        rd;
    logic [8:0]  off;
    logic [8:0]  cidx;
    logic [8:0]  gidx;
    logic [8:0]  tidx;
    int          c;
    int          s;
    int          k;
    int          b;
    run     = '0;
    cmp     = '0;
    ev      = '0;
    wmode   = '0;
    own_clr = '0;
    clr     = '0;
    src     = '0;
    md      = '0;
    syncv   = '0;
    bf      = '0;
    crest   = 1'b0;
    trough  = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    off     = '0;
    cidx    = '0;
    gidx    = '0;
    tidx    = '0;
    c       = 0;
    s       = 0;
    k       = 0;
    b       = 0;
    st_next = st_reg;
    st_next.trg_a = 1'b0;
    st_next.trg_b = 1'b0;
    st_next.trg_e = 1'b0;
    st_next.cap_prev = capture_in;

    run[2:0] = st_reg.run_ctl[2:0];
    run[3]   = st_reg.run_ctl[6];
    run[4]   = st_reg.run_ctl[7];
    run[5]   = st_reg.run5[2];
    run[6]   = st_reg.run5[1];
    run[7]   = st_reg.run5[0];
    syncv    = {st_reg.sync[7], st_reg.sync[6], st_reg.sync[2:0]};

    // Compare and capture events, one per general register
    for (int j = 0; j < 21; j++) begin
      c  = reg_chan(j);
      s  = j - reg_base(c);
      k  = (c < 5) ? c : 5 + s;
      md = st_reg.chctl[c][`MFT_CTL_MODE_POS + 2*s +: 2];
      if (c == 0 && s > 3) begin
        md = MFT_COMPARE;
      end
      // Width measuring is offered on channel 5 only
      if (c != 5 && md == MFT_WIDTH) begin
        md = MFT_CAPTURE;
      end
      st_next.pin_oe_n[j] = (md != MFT_COMPARE);
      cmp[j] = (md == MFT_COMPARE) && run[k] && (st_reg.cnt[k] == st_reg.gen[j]);
      ev[j]  = cmp[j];
      if (md == MFT_CAPTURE && capture_in[j] && !st_reg.cap_prev[j]) begin
        ev[j] = 1'b1;
        st_next.gen[j] = st_reg.cnt[k];
      end
      // pulse width ends on falling input
      if (md == MFT_WIDTH) begin
        wmode[s] = 1'b1;
        if (!capture_in[j] && st_reg.cap_prev[j]) begin
          ev[j] = 1'b1;
          st_next.gen[j] = st_reg.cnt[k];
        end
      end
      // pin moves only on a running match
      if (cmp[j]) begin
        st_next.pin[j] = !st_reg.pin[j];
      end
    end

    // buffer pairs on channels 0, 3, 4
    for (int ch = 0; ch < 5; ch++) begin
      b = reg_base(ch);
      if ((ch == 0 || ch > 2) && st_reg.chctl[ch][`MFT_CTL_BUF_POS]) begin
        if (cmp[b]) begin
          st_next.gen[b] = st_reg.gen[b + 2];
        end
        if (cmp[b + 1]) begin
          st_next.gen[b + 1] = st_reg.gen[b + 3];
        end
      end
    end
    // F reloads E on its match
    if (st_reg.chctl[0][`MFT_CTL_BUF_POS] && cmp[4]) begin
      st_next.gen[4] = st_reg.gen[5];
    end
    st_next.trg_e = cmp[4] && st_reg.chctl[0][`MFT_CTL_EREQ_POS];

    // Own clear sources per channel
    for (int ch = 0; ch < 5; ch++) begin
      b   = reg_base(ch);
      src = st_reg.chctl[ch][2:0];
      own_clr[ch] = (src == `MFT_CLR_A && ev[b]) || (src == `MFT_CLR_B && ev[b + 1]);
      if (ch == 0 || ch > 2) begin
        own_clr[ch] = own_clr[ch] || (src == `MFT_CLR_C && ev[b + 2])
                      || (src == `MFT_CLR_D && ev[b + 3]);
      end
    end
    // sync clear follows another sync channel
    for (int ch = 0; ch < 5; ch++) begin
      clr[ch] = own_clr[ch] || (syncv[ch] && st_reg.chctl[ch][2:0] == `MFT_CLR_SYNC
                && |(own_clr & syncv & ~(5'h01 << ch)));
    end

    // Crest and trough of counter 4
    crest  = run[4] && !st_reg.dir_down && (st_reg.cnt[4] == st_reg.gen[14]);
    trough = run[4] && st_reg.updown && st_reg.dir_down && (st_reg.cnt[4] == 16'h0000);

    // counting, channel 5 width mode counts while high
    for (int n = 0; n < 8; n++) begin
      if (run[n]) begin
        if (n == 4 && st_reg.updown) begin
          if (crest) begin
            st_next.dir_down = 1'b1;
            st_next.cnt[n]   = st_reg.cnt[n] - 16'h0001;
          end else if (trough) begin
            st_next.dir_down = 1'b0;
            st_next.cnt[n]   = st_reg.cnt[n] + 16'h0001;
          end else if (st_reg.dir_down) begin
            st_next.cnt[n]   = st_reg.cnt[n] - 16'h0001;
          end else begin
            st_next.cnt[n]   = st_reg.cnt[n] + 16'h0001;
          end
        end else if (n < 5 || !wmode[n - 5] || capture_in[13 + n]) begin
          st_next.cnt[n] = st_reg.cnt[n] + 16'h0001;
        end
      end
      if (n < 5 && clr[n]) begin
        st_next.cnt[n] = `MFT_CNT_RST;
      end
      if (n > 4 && wmode[n - 5] && ev[13 + n]) begin
        st_next.cnt[n] = `MFT_CNT_RST;
      end
    end
    if (!st_reg.updown) begin
      st_next.dir_down = 1'b0;
    end

    bf = st_reg.adcr[`MFT_BF_POS +: 2];
    if ((bf[0] && crest) || (bf[1] && trough)) begin
      st_next.cyc[0] = st_reg.cyc[2];
      st_next.cyc[1] = st_reg.cyc[3];
    end

    st_next.trg_a = run[4] && (st_reg.cnt[4] == st_reg.cyc[0])
                    && (st_reg.dir_down ? st_reg.adcr[`MFT_DT_A_POS]
                                        : st_reg.adcr[`MFT_UT_A_POS]);
    st_next.trg_b = run[4] && (st_reg.cnt[4] == st_reg.cyc[1])
                    && (st_reg.dir_down ? st_reg.adcr[`MFT_DT_B_POS]
                                        : st_reg.adcr[`MFT_UT_B_POS]);

    // Bus slave: one wait cycle, then answer
    off  = {address[8:2], 2'b00};
    cidx = off - `MFT_OFF_CNT;
    gidx = off - `MFT_OFF_GEN;
    tidx = off - `MFT_OFF_CTL;
    wr   = write && !st_reg.waitrequest;
    rd   = read && st_reg.waitrequest;
    st_next.waitrequest = !((read || write) && st_reg.waitrequest);

    // Read mux, unmapped reads return zero
    if (rd) begin
      st_next.rdata = '0;
      case (off)
        `MFT_OFF_RUN:   st_next.rdata[7:0]  = st_reg.run_ctl;
        `MFT_OFF_RUN5:  st_next.rdata[7:0]  = st_reg.run5;
        `MFT_OFF_SYNC:  st_next.rdata[7:0]  = st_reg.sync;
        `MFT_OFF_ADCR:  st_next.rdata[15:0] = st_reg.adcr;
        `MFT_OFF_CYC_A: st_next.rdata[15:0] = st_reg.cyc[0];
        `MFT_OFF_CYC_B: st_next.rdata[15:0] = st_reg.cyc[1];
        `MFT_OFF_BUF_A: st_next.rdata[15:0] = st_reg.cyc[2];
        `MFT_OFF_BUF_B: st_next.rdata[15:0] = st_reg.cyc[3];
        `MFT_OFF_UPDN:  st_next.rdata[1:0]  = {st_reg.dir_down, st_reg.updown};
        default: begin
          if (cidx < `MFT_SPAN_CNT) begin
            st_next.rdata[15:0] = st_reg.cnt[cidx[4:2]];
          end else if (gidx < `MFT_SPAN_GEN) begin
            st_next.rdata[15:0] = st_reg.gen[gidx[6:2]];
          end else if (tidx < `MFT_SPAN_CTL) begin
            st_next.rdata[22:0] = st_reg.chctl[tidx[4:2]];
          end
        end
      endcase
    end

    // Writes take effect on the accepting edge and win over counting
    // narrow writes to wide registers ignored
    if (wr && byteenable[0]) begin
      case (off)
        `MFT_OFF_RUN:  st_next.run_ctl = writedata[7:0] & `MFT_RUN_MASK;
        `MFT_OFF_RUN5: st_next.run5    = writedata[7:0] & `MFT_RUN5_MASK;
        `MFT_OFF_SYNC: st_next.sync    = writedata[7:0] & `MFT_SYNC_MASK;
        `MFT_OFF_UPDN: st_next.updown  = writedata[0];
        default: begin
        end
      endcase
    end
    if (wr && byteenable[1:0] == 2'b11) begin
      case (off)
        `MFT_OFF_ADCR:  st_next.adcr   = writedata[15:0] & `MFT_ADCR_MASK;
        `MFT_OFF_CYC_A: st_next.cyc[0] = writedata[15:0];
        `MFT_OFF_CYC_B: st_next.cyc[1] = writedata[15:0];
        `MFT_OFF_BUF_A: st_next.cyc[2] = writedata[15:0];
        `MFT_OFF_BUF_B: st_next.cyc[3] = writedata[15:0];
        default: begin
          if (cidx < `MFT_SPAN_CNT) begin
            k = int'(cidx[4:2]);
            st_next.cnt[k] = writedata[15:0];
            // synchronous preset of all sync counters
            if (k < 5 && syncv[k]) begin
              for (int ch = 0; ch < 5; ch++) begin
                if (syncv[ch]) begin
                  st_next.cnt[ch] = writedata[15:0];
                end
              end
            end
          end else if (gidx < `MFT_SPAN_GEN) begin
            st_next.gen[gidx[6:2]] = writedata[15:0];
          end
        end
      endcase
    end
    if (wr && byteenable == 4'hF && tidx < `MFT_SPAN_CTL) begin
      c = int'(tidx[4:2]);
      st_next.chctl[c] = writedata[22:0];
      // stopped channel pins take initial level
      for (int t = 0; t < 6; t++) begin
        b = reg_base(c) + t;
        k = (c < 5) ? c : 5 + t;
        if (b < 21 && reg_chan(b) == c && !run[k]) begin
          st_next.pin[b] = writedata[`MFT_CTL_INIT_POS + t];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // counters reset to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flops
  assign readdata            = st_reg.rdata;
  assign waitrequest         = st_reg.waitrequest;
  assign timer_io_pin_out    = st_reg.pin;
  assign timer_io_pin_oe_n   = st_reg.pin_oe_n;
  assign adc_start_request_a = st_reg.trg_a;
  assign adc_start_request_b = st_reg.trg_b;
  assign ch0_adc_request     = st_reg.trg_e;

endmodule

// [sim/mft_timer_properties.sv]
// Port checker of the timer block.
// Assumes a bind onto mft_timer, one clock domain.
`timescale 1ns/100ps
module mft_timer_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [8:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [20:0] capture_in,
  input wire logic [20:0] timer_io_pin_out,
  input wire logic [20:0] timer_io_pin_oe_n,
  input wire logic        adc_start_request_a,
  input wire logic        adc_start_request_b,
  input wire logic        ch0_adc_request
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // --------
  // Bus handshake
  // --------
  // one wait cycle
  chk_wait_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("bus not answered");
  chk_wait_single: assert property (
    !waitrequest |=> waitrequest) else $error("answer too long");
  chk_no_stray_ack: assert property (
    !read && !write |=> waitrequest) else $error("stray answer");
  // --------
  // Register read values
  // --------
  // reserved bits read zero
  chk_run_reserved: assert property (
    read && !waitrequest && (address == 9'h000 || address == 9'h008)
    |-> (readdata & 32'hFFFF_FF38) == 32'h0) else $error("reserved run bits set");
  chk_run5_reserved: assert property (
    read && !waitrequest && address == 9'h004 |-> readdata[31:3] == 29'h0)
    else $error("reserved ch5 bits set");
  // counters and general registers are 16 bits
  chk_wide_upper: assert property (
    read && !waitrequest && (address[8:6] == 3'h1 || address[8:7] == 2'h1)
    |-> readdata[31:16] == 16'h0) else $error("wide register upper bits set");
  // --------
  // Converter starts
  // --------
  // single pulse per match
  chk_pulse_a: assert property (
    adc_start_request_a |=> !adc_start_request_a) else $error("start A too long");
  chk_pulse_e: assert property (
    ch0_adc_request |=> !ch0_adc_request) else $error("start E too long");
endmodule
bind mft_timer mft_timer_properties u_chk (.clock, .rst, .address, .read, .write,
  .byteenable, .writedata, .readdata, .waitrequest, .capture_in, .timer_io_pin_out,
  .timer_io_pin_oe_n, .adc_start_request_a, .adc_start_request_b, .ch0_adc_request);

// [sim/mft_far_side.sv]
// Far side: converter start inputs and timer pin wires.
// Assumes registered start pulses, one clock.
`timescale 1ns/100ps
module mft_far_side (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        adc_start_request_a,
  input  wire logic        adc_start_request_b,
  input  wire logic        ch0_adc_request,
  input  wire logic [20:0] timer_io_pin_out,
  input  wire logic [20:0] timer_io_pin_oe_n,
  input  wire logic [20:0] ext_drive,
  output logic [20:0]      pin_level,
  output logic [7:0]       starts_a,
  output logic [7:0]       starts_b,
  output logic [7:0]       starts_e
);
  // Wire level: timer drives when enabled, else the outside source
  assign pin_level = (~timer_io_pin_oe_n & timer_io_pin_out) | (timer_io_pin_oe_n & ext_drive);
  // Converter takes every pulse as one start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      starts_a <= 8'h00;
      starts_b <= 8'h00;
      starts_e <= 8'h00;
    end else begin
      starts_a <= starts_a + {7'h00, adc_start_request_a};
      starts_b <= starts_b + {7'h00, adc_start_request_b};
      starts_e <= starts_e + {7'h00, ch0_adc_request};
    end
  end
endmodule

// [sim/mft_timer_tb.sv]
// Bench of the timer: registers, counting, sync, starts, pins, reset.
// Assumes the slave answers each request before the watchdog expires.
`timescale 1ns/100ps
`include "mft_cfg.svh"
module mft_timer_tb;
  typedef struct {
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } mft_row_type;
  logic        clock, rst, read, write, waitrequest, req_a, req_b, req_e;
  logic [8:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd;
  logic [20:0] cap, pin_out, pin_oe_n, ext_drive;
  logic [7:0]  n_a, n_b, n_e;
  int          num_errors, n_checks;
  // Write then read back each row; upper bits must not stick, unmapped reads zero
  mft_row_type rows [11] = '{
    '{`MFT_OFF_RUN5, 32'h5, 32'h5}, '{`MFT_OFF_RUN5, 32'h0, 32'h0},
    '{`MFT_OFF_SYNC, 32'hC7, 32'hC7}, '{`MFT_OFF_SYNC, 32'h0, 32'h0},
    '{`MFT_OFF_ADCR, 32'h40A0, 32'h40A0}, '{`MFT_OFF_ADCR, 32'h0, 32'h0},
    '{`MFT_OFF_CYC_B, 32'h1234_5678, 32'h5678}, '{`MFT_OFF_BUF_B, 32'hABCD, 32'hABCD},
    '{`MFT_OFF_GEN + 9'h00C, 32'h5555, 32'h5555},
    '{`MFT_OFF_CNT + 9'h01C, 32'h0102, 32'h0102}, '{9'h1FC, 32'hFFFF, 32'h0}};

  mft_timer uut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .capture_in(cap), .timer_io_pin_out(pin_out),
    .timer_io_pin_oe_n(pin_oe_n), .adc_start_request_a(req_a),
    .adc_start_request_b(req_b), .ch0_adc_request(req_e));
  mft_far_side far (.clock(clock), .rst(rst), .adc_start_request_a(req_a),
    .adc_start_request_b(req_b), .ch0_adc_request(req_e), .timer_io_pin_out(pin_out),
    .timer_io_pin_oe_n(pin_oe_n), .ext_drive(ext_drive), .pin_level(cap),
    .starts_a(n_a), .starts_b(n_b), .starts_e(n_e));

  // Free-running clock
  always #5 clock = ~clock;

  // --------
  // Bus and check tasks
  // --------
  // Request held until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic wr_en, input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // Run a counter briefly, stop, then it must hold
  task automatic run_hold(input logic [8:0] ctl, input logic [8:0] cnt, input logic [31:0] b);
    logic [31:0] v;
    wr(cnt, 32'h0);
    wr(ctl, b);
    wr(ctl, 32'h0);
    bus(1'b0, cnt, 32'h0);
    v = rd;
    check({31'h0, v > 0 && v < 32'h10}, 32'h1);
    rchk(cnt, v);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  // --------
  // Main sequence
  // --------
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 9'h0;
    byteenable = 4'hF; // whole words only
    writedata = 32'h0;
    ext_drive = 21'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].exp);
    end
    run_hold(`MFT_OFF_RUN, `MFT_OFF_CNT + 9'h004, 32'h02);
    run_hold(`MFT_OFF_RUN, `MFT_OFF_CNT + 9'h010, 32'h80);
    run_hold(`MFT_OFF_RUN5, `MFT_OFF_CNT + 9'h014, 32'h04);
    run_hold(`MFT_OFF_RUN5, `MFT_OFF_CNT + 9'h01C, 32'h01);
    wr(`MFT_OFF_SYNC, 32'h03); // two channels
    wr(`MFT_OFF_CNT, 32'h0777);
    rchk(`MFT_OFF_CNT + 9'h004, 32'h0777);
    rchk(`MFT_OFF_CNT + 9'h008, 32'h0000);
    wr(`MFT_OFF_SYNC, 32'h0);
    // Pass 0: B only, no transfer; pass 1: A, crest transfer re-arms A
    wr(`MFT_OFF_CYC_A, 32'h10);
    wr(`MFT_OFF_CYC_B, 32'h20);
    wr(`MFT_OFF_GEN + 9'h038, 32'h30);
    for (int p = 0; p < 2; p++) begin
      wr(`MFT_OFF_BUF_A, 32'h40 + 32'(p));
      wr(`MFT_OFF_ADCR, p ? 32'h4080 : 32'h0020);
      wr(`MFT_OFF_CNT + 9'h010, 32'h0);
      wr(`MFT_OFF_RUN, 32'h80);
      repeat (80) @(posedge clock);
      wr(`MFT_OFF_RUN, 32'h0);
      check({24'h0, n_a}, 32'(2 * p));
      check({24'h0, n_b}, 32'h1);
      rchk(`MFT_OFF_CYC_A, p ? 32'h41 : 32'h10);
      rchk(`MFT_OFF_CYC_B, p ? 32'hABCD : 32'h20);
    end
    // channel 0 E match starts converter
    wr(`MFT_OFF_GEN + 9'h010, 32'h8);
    wr(`MFT_OFF_CTL, 32'h0040_0000);
    wr(`MFT_OFF_CNT, 32'h0);
    wr(`MFT_OFF_RUN, 32'h01);
    repeat (30) @(posedge clock);
    wr(`MFT_OFF_RUN, 32'h0);
    check({24'h0, n_e}, 32'h1);
    // control write while stopped loads pin
    wr(`MFT_OFF_CTL + 9'h004, 32'h0001_0000);
    @(negedge clock);
    check({31'h0, pin_out[6]}, 32'h1);
    wr(`MFT_OFF_CTL + 9'h004, 32'h0);
    @(negedge clock);
    check({31'h0, pin_out[6]}, 32'h0);
    check({31'h0, pin_oe_n[6]}, 32'h0);
    wr(`MFT_OFF_GEN + 9'h018, 32'h5);
    wr(`MFT_OFF_CNT + 9'h004, 32'h0);
    wr(`MFT_OFF_RUN, 32'h02);
    repeat (20) @(posedge clock);
    wr(`MFT_OFF_RUN, 32'h0);
    repeat (10) @(negedge clock);
    check({31'h0, pin_out[6]}, 32'h1);
    // ch0 clears on A match, ch1 follows by sync clear
    wr(`MFT_OFF_GEN, 32'h10);
    wr(`MFT_OFF_CTL, 32'h1); // set while stopped
    wr(`MFT_OFF_CTL + 9'h004, 32'h3);
    wr(`MFT_OFF_SYNC, 32'h03);
    wr(`MFT_OFF_CNT, 32'h0);
    wr(`MFT_OFF_RUN, 32'h03);
    repeat (40) @(posedge clock);
    wr(`MFT_OFF_RUN, 32'h0);
    bus(1'b0, `MFT_OFF_CNT, 32'h0);
    check({31'h0, rd < 32'h11}, 32'h1);
    rchk(`MFT_OFF_CNT + 9'h004, rd);
    wr(`MFT_OFF_SYNC, 32'h0);
    // capture on ch2 A takes the held count
    wr(`MFT_OFF_CTL + 9'h008, 32'h10);
    wr(`MFT_OFF_CNT + 9'h008, 32'h0100);
    ext_drive[8] <= 1'b1;
    rchk(`MFT_OFF_GEN + 9'h020, 32'h0100);
    check({31'h0, pin_oe_n[8]}, 32'h1);
    // ch5 U measures a six-cycle high pulse
    wr(`MFT_OFF_CTL + 9'h014, 32'h20);
    wr(`MFT_OFF_CNT + 9'h014, 32'h0);
    wr(`MFT_OFF_RUN5, 32'h04);
    ext_drive[18] <= 1'b1;
    repeat (6) @(posedge clock);
    ext_drive[18] <= 1'b0;
    rchk(`MFT_OFF_GEN + 9'h048, 32'h6);
    rchk(`MFT_OFF_CNT + 9'h014, 32'h0);
    wr(`MFT_OFF_RUN5, 32'h0);
    // ch3 C reloads A on each A match
    wr(`MFT_OFF_GEN + 9'h028, 32'h4);
    wr(`MFT_OFF_GEN + 9'h030, 32'h9);
    wr(`MFT_OFF_CTL + 9'h00C, 32'h8);
    wr(`MFT_OFF_CNT + 9'h00C, 32'h0);
    wr(`MFT_OFF_RUN, 32'h40);
    repeat (20) @(posedge clock);
    wr(`MFT_OFF_RUN, 32'h0);
    rchk(`MFT_OFF_GEN + 9'h028, 32'h9);
    // up/down ch4: up-count start, copy at trough
    wr(`MFT_OFF_UPDN, 32'h1);
    wr(`MFT_OFF_CYC_A, 32'h20);
    wr(`MFT_OFF_BUF_A, 32'h42);
    wr(`MFT_OFF_ADCR, 32'h8040);
    wr(`MFT_OFF_CNT + 9'h010, 32'h0);
    wr(`MFT_OFF_RUN, 32'h80);
    repeat (100) @(posedge clock);
    wr(`MFT_OFF_RUN, 32'h0);
    check({24'h0, n_a}, 32'h3);
    rchk(`MFT_OFF_CYC_A, 32'h42);
    rchk(`MFT_OFF_UPDN, 32'h1);
    // Reset in mid-run, then reset values
    wr(`MFT_OFF_RUN, 32'h02);
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++)
      rchk(`MFT_OFF_CNT + 9'(4 * k), 32'h0);
    for (int j = 0; j < 21; j++)
      rchk(`MFT_OFF_GEN + 9'(4 * j), 32'hFFFF);
    for (int c = 0; c < 4; c++)
      rchk(`MFT_OFF_CYC_A + 9'(4 * c), 32'hFFFF);
    rchk(`MFT_OFF_RUN, 32'h0);
    rchk(`MFT_OFF_RUN5, 32'h0);
    rchk(`MFT_OFF_SYNC, 32'h0);
    check({11'h0, pin_oe_n}, 32'h0);
    finish_test();
  end
endmodule
